// >>> core/icc_consts.vh
// constants for the input channel conditioner: offsets, fields, resets, timing
// assumes the 125 MHz system clock; included by every design file
`ifndef ICC_CONSTS_VH
`define ICC_CONSTS_VH

// clock and timing
`define ICC_CLK_MHZ        125
`define ICC_TICK_NS        1000
`define ICC_TICK_CYC       ((`ICC_TICK_NS * `ICC_CLK_MHZ) / 1000)
`define ICC_GATE_MS        1000
`define ICC_GATE_CYC       (`ICC_GATE_MS * 1000 * `ICC_CLK_MHZ)

// global registers, byte addresses
`define ICC_OFF_LEVEL      8'h00
`define ICC_OFF_LATCH      8'h04
`define ICC_OFF_CMD        8'h08
`define ICC_OFF_IRQ_STAT   8'h0C
`define ICC_OFF_IRQ_MASK   8'h10

// channel region: address bit 7 set, channel in [6:4], register in [3:2]
`define ICC_CH_REGION_BIT  7
`define ICC_CH_REG_CFG     2'h0
`define ICC_CH_REG_FILT    2'h1
`define ICC_CH_REG_COUNT   2'h2
`define ICC_CH_REG_FREQ    2'h3

// channel config fields
`define ICC_CFG_MODE_LSB   0
`define ICC_CFG_MODE_W     3
`define ICC_CFG_INV_BIT    3
`define ICC_CFG_RUN_BIT    4
`define ICC_CFG_KEEP_BIT   5
`define ICC_CFG_RESET      8'h00
`define ICC_FILT_RESET     32'h0001_0001

// mode codes
`define ICC_MODE_LEVEL     3'h0
`define ICC_MODE_COUNT     3'h1
`define ICC_MODE_RISE      3'h2
`define ICC_MODE_FALL      3'h3
`define ICC_MODE_FREQ      3'h4

`endif

// >>> core/icc_glitch_filter.v
// one channel of level filter with separate minimum high and low widths
// assumes a one-cycle sampling tick from the parent and synchronous input
`timescale 1ns/10ps
`include "icc_consts.vh"

module icc_glitch_filter
(
    // clocking
    input  wire        clock,
    input  wire        sys_rst,
    input  wire        clk_en,
    input  wire        tick,
    // signal
    input  wire        raw_in,
    input  wire [15:0] min_high,
    input  wire [15:0] min_low,
    output reg         level_q
);

    reg  [15:0] stable_q;
    wire [15:0] width;
    wire [15:0] need;

    assign width = raw_in ? min_high : min_low;
    // a width of zero behaves as one so the filter can never lock up
    assign need  = (width == 16'h0000) ? 16'h0001 : width;

    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            stable_q <= 16'h0000;
            level_q  <= 1'b0;
        end
        else if (clk_en)
        begin
            if (raw_in == level_q)
                stable_q <= 16'h0000;
            else if (tick)
            begin
                if (stable_q + 16'h0001 >= need)
                begin
                    level_q  <= raw_in;
                    stable_q <= 16'h0000;
                end
                else
                    stable_q <= stable_q + 16'h0001;
            end
        end
    end

endmodule

// >>> core/icc_freq_meter.v
// one channel of frequency measurement: rising edges counted over a gate
// assumes a one-cycle rise pulse from the conditioned input
`timescale 1ns/10ps
`include "icc_consts.vh"

module icc_freq_meter #(
    parameter FREQ_W   = 32,
    parameter GATE_CYC = `ICC_GATE_CYC
)
(
    // clocking
    input  wire              clock,
    input  wire              sys_rst,
    input  wire              clk_en,
    // signal
    input  wire              enable,
    input  wire              rise,
    output reg  [FREQ_W-1:0] freq_q
);

    reg  [31:0]       gate_q;
    reg  [FREQ_W-1:0] edges_q;
    wire              gate_end;

    assign gate_end = (gate_q == GATE_CYC - 1);

    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            gate_q  <= 32'h0000_0000;
            edges_q <= {FREQ_W{1'b0}};
            freq_q  <= {FREQ_W{1'b0}};
        end
        else if (clk_en)
        begin
            if (!enable)
            begin
                // leaving the mode restarts the gate and clears the reading
                gate_q  <= 32'h0000_0000;
                edges_q <= {FREQ_W{1'b0}};
                freq_q  <= {FREQ_W{1'b0}};
            end
            else if (gate_end)
            begin
                gate_q  <= 32'h0000_0000;
                // an edge on the closing cycle still belongs to this gate
                freq_q  <= edges_q + {{(FREQ_W-1){1'b0}}, rise};
                edges_q <= {FREQ_W{1'b0}};
            end
            else
            begin
                gate_q  <= gate_q + 32'h0000_0001;
                edges_q <= edges_q + {{(FREQ_W-1){1'b0}}, rise};
            end
        end
    end

endmodule

// >>> core/input_channel_conditioner.v
// input channel conditioner: inversion, glitch filter and five modes per channel
// assumes synchronous field inputs, an Avalon-MM master and one 125 MHz clock
//
// Overview of operation
// - inversion flips the sensed level first; an idle input then reads one
// - filter rejects pulses shorter than programmable min high or min low width
// - each channel runs exactly one mode: level, counter, rise, fall latch, freq
// - level mode shows the conditioned level as a readable status bit
// - counter mode adds one per conditioned pulse on that channel
// - host starts or stops counting; stopped count holds, running count is live
// - host clear command forces the channel count to zero
// - with keep enabled the count survives a system reset, but not a power-on reset
// - rise latch mode: rising edge sets latch bit until host clears it
// - fall latch mode: falling edge sets latch bit until host clears it
// - latch edges are taken after inversion, so inversion swaps the edge
// - frequency mode measures edge rate and shows it in a channel register
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "icc_consts.vh"

module input_channel_conditioner #(
    parameter NCH      = 4,
    parameter CNT_W    = 32,
    parameter GATE_CYC = `ICC_GATE_CYC
)
(
    // clocking and resets
    input  wire           clock,
    input  wire           sys_rst,
    input  wire           power_on_rst,
    input  wire           clk_en,
    // field inputs
    input  wire [NCH-1:0] sensed_input,
    // avalon-mm slave
    input  wire [7:0]     address,
    input  wire           read,
    input  wire           write,
    input  wire [31:0]    writedata,
    input  wire [3:0]     byteenable,
    output reg  [31:0]    readdata,
    output wire           waitrequest,
    // interrupt
    output wire           irq
);

    // bus handshake
    reg             ack_q;
    reg  [31:0]     rdata_d;
    wire            wr_hit;
    wire            in_ch;
    wire [2:0]      sel_ch;
    wire [1:0]      sel_reg;
    wire [31:0]     be_mask;

    // sampling tick
    reg  [15:0]     tick_cnt_q;
    wire            tick;

    // global status
    reg  [NCH-1:0]  irq_mask_q;
    wire [NCH-1:0]  level_all;
    wire [NCH-1:0]  latch_all;
    wire [NCH-1:0]  irq_stat_all;
    wire [8*NCH-1:0]     cfg_all;
    wire [32*NCH-1:0]    filt_all;
    wire [CNT_W*NCH-1:0] count_all;
    wire [CNT_W*NCH-1:0] freq_all;

    wire            rst_all;
    wire            wr_latch;
    wire            wr_cmd;
    wire            wr_istat;
    wire            wr_imask;

    assign rst_all = sys_rst | power_on_rst;

    // one wait state: the answer comes on the second cycle with the clock enable high
    // a frozen ack must not finish an access that the frozen logic cannot take
    assign waitrequest = (read | write) & ~(ack_q & clk_en);
    assign wr_hit      = write & ack_q & clk_en;

    assign in_ch   = address[`ICC_CH_REGION_BIT];
    assign sel_ch  = address[6:4];
    assign sel_reg = address[3:2];
    assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                      {8{byteenable[1]}}, {8{byteenable[0]}}};

    assign wr_latch = wr_hit & ~in_ch & (address == `ICC_OFF_LATCH);
    assign wr_cmd   = wr_hit & ~in_ch & (address == `ICC_OFF_CMD);
    assign wr_istat = wr_hit & ~in_ch & (address == `ICC_OFF_IRQ_STAT);
    assign wr_imask = wr_hit & ~in_ch & (address == `ICC_OFF_IRQ_MASK);

    assign irq = |(irq_stat_all & irq_mask_q);

    assign tick = (tick_cnt_q == `ICC_TICK_CYC - 1);

    always @(posedge clock)
    begin
        if (rst_all)
            tick_cnt_q <= 16'h0000;
        else if (clk_en)
        begin
            if (tick)
                tick_cnt_q <= 16'h0000;
            else
                tick_cnt_q <= tick_cnt_q + 16'h0001;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1)
        begin : chan
            reg  [7:0]       cfg_q;
            reg              keep_q;
            reg  [31:0]      filt_q;
            reg  [CNT_W-1:0] count_q;
            reg              prev_q;
            reg              latch_q;
            reg              istat_q;
            wire             raw;
            wire             cond;
            wire             rise;
            wire             fall;
            wire [2:0]       mode;
            wire             wr_cfg;
            wire             wr_filt;
            wire             latch_set;
            wire             latch_clr;
            wire             cnt_clr;

            assign mode    = cfg_q[`ICC_CFG_MODE_LSB +: `ICC_CFG_MODE_W];
            assign wr_cfg  = wr_hit & in_ch & (sel_ch == g) &
                             (sel_reg == `ICC_CH_REG_CFG);
            assign wr_filt = wr_hit & in_ch & (sel_ch == g) &
                             (sel_reg == `ICC_CH_REG_FILT);

            assign raw = sensed_input[g] ^ cfg_q[`ICC_CFG_INV_BIT];

            icc_glitch_filter u_filt (
                .clock    (clock),
                .sys_rst  (rst_all),
                .clk_en   (clk_en),
                .tick     (tick),
                .raw_in   (raw),
                .min_high (filt_q[15:0]),
                .min_low  (filt_q[31:16]),
                .level_q  (cond)
            );

            always @(posedge clock)
            begin
                if (rst_all)
                    prev_q <= 1'b0;
                else if (clk_en)
                    prev_q <= cond;
            end

            // edges come from the already inverted and filtered level
            assign rise = cond & ~prev_q;
            assign fall = ~cond & prev_q;

            assign latch_set = ((mode == `ICC_MODE_RISE) & rise) |
                               ((mode == `ICC_MODE_FALL) & fall);
            assign latch_clr = wr_latch & writedata[g] & byteenable[g/8];
            assign cnt_clr   = wr_cmd & writedata[g] & byteenable[g/8];

            // config; keep lives in the power-on domain so it outlasts sys_rst
            always @(posedge clock)
            begin
                if (rst_all)
                begin
                    cfg_q  <= `ICC_CFG_RESET;
                    filt_q <= `ICC_FILT_RESET;
                end
                else if (clk_en)
                begin
                    if (wr_cfg & byteenable[0])
                        cfg_q <= writedata[7:0];
                    if (wr_filt)
                        filt_q <= (filt_q & ~be_mask) | (writedata & be_mask);
                end
            end

            always @(posedge clock)
            begin
                if (power_on_rst)
                    keep_q <= 1'b0;
                else if (clk_en & wr_cfg & byteenable[0])
                    keep_q <= writedata[`ICC_CFG_KEEP_BIT];
            end

            // counter: power-on, an unkept system reset or the host clear command zeroes it
            always @(posedge clock)
            begin
                if (power_on_rst | (sys_rst & ~keep_q))
                    count_q <= {CNT_W{1'b0}};
                else if (sys_rst)
                    count_q <= count_q;
                else if (clk_en)
                begin
                    if (cnt_clr)
                        count_q <= {CNT_W{1'b0}};
                    else if ((mode == `ICC_MODE_COUNT) & cfg_q[`ICC_CFG_RUN_BIT] & rise)
                        count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end

            // sticky bits: a new set wins over a clear in the same cycle
            always @(posedge clock)
            begin
                if (rst_all)
                begin
                    latch_q <= 1'b0;
                    istat_q <= 1'b0;
                end
                else if (clk_en)
                begin
                    latch_q <= latch_set | (latch_q & ~latch_clr);
                    istat_q <= latch_set |
                               (istat_q & ~(wr_istat & writedata[g] & byteenable[g/8]));
                end
            end

            icc_freq_meter #(
                .FREQ_W   (CNT_W),
                .GATE_CYC (GATE_CYC)
            ) u_freq (
                .clock    (clock),
                .sys_rst  (rst_all),
                .clk_en   (clk_en),
                .enable   (mode == `ICC_MODE_FREQ),
                .rise     (rise),
                .freq_q   (freq_all[g*CNT_W +: CNT_W])
            );

            assign level_all[g]             = cond;
            assign latch_all[g]             = latch_q;
            assign irq_stat_all[g]          = istat_q;
            assign cfg_all[g*8 +: 8]        = {cfg_q[7:6], keep_q, cfg_q[4:0]};
            assign filt_all[g*32 +: 32]     = filt_q;
            assign count_all[g*CNT_W +: CNT_W] = count_q;
        end
    endgenerate

    // interrupt mask
    always @(posedge clock)
    begin
        if (rst_all)
            irq_mask_q <= {NCH{1'b0}};
        else if (clk_en & wr_imask)
            irq_mask_q <= (irq_mask_q & ~be_mask[NCH-1:0]) |
                          (writedata[NCH-1:0] & be_mask[NCH-1:0]);
    end

    // read mux; unmapped addresses and channels read zero
    always @*
    begin
        rdata_d = 32'h0000_0000;
        if (in_ch)
        begin
            if (sel_ch < NCH)
            begin
                case (sel_reg)
                    `ICC_CH_REG_CFG:
                        rdata_d[7:0] = cfg_all[sel_ch*8 +: 8];
                    `ICC_CH_REG_FILT:
                        rdata_d = filt_all[sel_ch*32 +: 32];
                    `ICC_CH_REG_COUNT:
                        rdata_d[CNT_W-1:0] = count_all[sel_ch*CNT_W +: CNT_W];
                    `ICC_CH_REG_FREQ:
                        rdata_d[CNT_W-1:0] = freq_all[sel_ch*CNT_W +: CNT_W];
                    default:
                        rdata_d = 32'h0000_0000;
                endcase
            end
        end
        else
        begin
            case (address)
                `ICC_OFF_LEVEL:    rdata_d[NCH-1:0] = level_all;
                `ICC_OFF_LATCH:    rdata_d[NCH-1:0] = latch_all;
                `ICC_OFF_IRQ_STAT: rdata_d[NCH-1:0] = irq_stat_all;
                `ICC_OFF_IRQ_MASK: rdata_d[NCH-1:0] = irq_mask_q;
                default:           rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always @(posedge clock)
    begin
        if (rst_all)
        begin
            ack_q    <= 1'b0;
            readdata <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            ack_q <= (read | write) & ~ack_q;
            if (read & ~ack_q)
                readdata <= rdata_d;
        end
    end

endmodule

// >>> dv/icc_field_source.sv
// field source model: push-pull drivers on the discrete input lines
// assumes the bench calls hold() from its main sequence, one caller at a time
`timescale 1ns/10ps
module icc_field_source #(
    parameter NCH = 4
)
(
    // clocking
    input  wire logic           clock,
    // field lines
    output logic     [NCH-1:0] lines
);
    // an idle source leaves its line low, which inversion reads as one
    initial lines = '0;

    // level changes just after an edge and stays for cyc edges
    task hold(input logic [NCH-1:0] v, input int cyc);
        @(posedge clock);
        lines <= v;
        repeat (cyc) @(posedge clock);
    endtask
endmodule

// >>> dv/icc_asserts.sv
// checker: bus wait states, reset values, sticky latches and irq mask
// assumes it is bound to the conditioner top and sees its ports only
`timescale 1ns/10ps
module icc_asserts #(
    parameter NCH = 4
)
(
    // clocking and resets
    input wire           clock,
    input wire           sys_rst,
    input wire           power_on_rst,
    input wire           clk_en,
    // field inputs
    input wire [NCH-1:0] sensed_input,
    // avalon-mm slave
    input wire [7:0]     address,
    input wire           read,
    input wire           write,
    input wire [31:0]    writedata,
    input wire [3:0]     byteenable,
    input wire [31:0]    readdata,
    input wire           waitrequest,
    // interrupt
    input wire           irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst || power_on_rst);

    wire           rd_done = read && !waitrequest && clk_en;
    wire           wr_done = write && !waitrequest && clk_en;
    reg  [NCH-1:0] mask_q;
    reg  [NCH-1:0] latch_q;
    reg            seen_q;

    // shadow of the mask and of the last latch word read back
    always @(posedge clock)
    begin
        if (sys_rst || power_on_rst)
        begin
            mask_q  <= '0;
            latch_q <= '0;
            seen_q  <= 1'b0;
        end
        else
        begin
            if (wr_done && address == 8'h10 && byteenable[0])
                mask_q <= writedata[NCH-1:0];
            if (wr_done && address == 8'h04)
                seen_q <= 1'b0;
            else if (rd_done && address == 8'h04)
            begin
                latch_q <= readdata[NCH-1:0];
                seen_q  <= 1'b1;
            end
        end
    end

    property p_one_wait;
        $rose(read || write) && clk_en |-> waitrequest ##1 (!waitrequest || !clk_en);
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("access did not finish after one wait state");

    property p_idle_free;
        !(read || write) |-> !waitrequest;
    endproperty
    a_idle_free: assert property (p_idle_free)
        else $error("wait state raised with no access");

    property p_rst_clean;
        $fell(sys_rst) || $fell(power_on_rst) |-> !irq && readdata == 32'h0000_0000;
    endproperty
    a_rst_clean: assert property (p_rst_clean)
        else $error("irq or read data not clear after reset");

    property p_latch_sticky;
        rd_done && address == 8'h04 && seen_q |-> (readdata[NCH-1:0] & latch_q) == latch_q;
    endproperty
    a_latch_sticky: assert property (p_latch_sticky)
        else $error("latch bit dropped without a clear");

    property p_irq_mask;
        irq |-> mask_q != '0;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("irq high with every source masked");

    property p_mask_read;
        rd_done && address == 8'h10 |-> readdata[NCH-1:0] == mask_q;
    endproperty
    a_mask_read: assert property (p_mask_read)
        else $error("mask read back differs from last write");

    property p_chan_range;
        rd_done && address[7] && address[6:4] >= NCH |-> readdata == 32'h0000_0000;
    endproperty
    a_chan_range: assert property (p_chan_range)
        else $error("absent channel read nonzero");

    property p_level_width;
        rd_done && address == 8'h00 |-> (readdata >> NCH) == 32'h0000_0000;
    endproperty
    a_level_width: assert property (p_level_width)
        else $error("level word has bits above the channels");
endmodule

bind input_channel_conditioner icc_asserts #(.NCH(NCH)) icc_asserts_i (
    .clock(clock), .sys_rst(sys_rst), .power_on_rst(power_on_rst), .clk_en(clk_en),
    .sensed_input(sensed_input), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq));

// >>> dv/tb_input_channel_conditioner.sv
// testbench: register traffic over avalon-mm against a level, count and latch model
// assumes the field source model and the checker are compiled before it
`timescale 1ns/10ps
module tb_input_channel_conditioner;
    localparam NCH  = 4;
    localparam GATE = 10000;   // short gate keeps the run small

    logic           clock = 1'b0;
    logic           sys_rst = 1'b1;
    logic           power_on_rst = 1'b1;
    logic           clk_en = 1'b1;
    logic           read = 1'b0;
    logic           write = 1'b0;
    logic [7:0]     address = 8'h00;
    logic [31:0]    writedata = 32'h0000_0000;
    logic [31:0]    readdata;
    logic [31:0]    q;
    logic           waitrequest;
    logic           irq;
    logic           run = 1'b0;
    logic [NCH-1:0] lines;
    logic [NCH-1:0] lv = 4'h0;
    logic [NCH-1:0] inv = 4'hC;
    logic [NCH-1:0] lat = 4'h0;
    int             err_count = 0;
    int             num_checks = 0;
    int             cnt = 0;
    int             seed;

    always #4 clock = ~clock;

    icc_field_source #(.NCH(NCH)) icc_field_source_i (.clock(clock), .lines(lines));

    input_channel_conditioner #(.NCH(NCH), .GATE_CYC(GATE)) input_channel_conditioner_i (
        .clock(clock), .sys_rst(sys_rst), .power_on_rst(power_on_rst), .clk_en(clk_en),
        .sensed_input(lines), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq));

    task give_verdict;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one access; request held until waitrequest is sampled low
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        // with the clock enable high every access sees exactly one wait state
        chk(n, 2);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(q, e);
    endtask

    // advance the model, drive the lines, then compare the level word
    task step(input logic [NCH-1:0] v);
        logic [NCH-1:0] nl;
        nl = v ^ inv;
        cnt += int'(run && !lv[0] && nl[0]);
        lat[1] |= !lv[1] & nl[1];
        lat[2] |= lv[2] & !nl[2];
        lv = nl;
        icc_field_source_i.hold(v, 600);
        rd(8'h00, {28'h000_0000, lv});
    endtask

    initial
    begin
        repeat (80000) @(posedge clock);
        err_count++;
        give_verdict;
    end

    initial
    begin
        seed = $urandom(32'h0000_6d25);
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        power_on_rst <= 1'b0;
        rd(8'h80, 32'h0000_0000);
        rd(8'h84, 32'h0001_0001);
        rd(8'h20, 32'h0000_0000);
        rd(8'hC0, 32'h0000_0000);
        for (int g = 0; g < NCH; g++)
            bus(1'b1, 8'h84 + 8'(g * 16), 32'h0003_0003);
        bus(1'b1, 8'h80, 32'h0000_0011);
        bus(1'b1, 8'h90, 32'h0000_0002);
        bus(1'b1, 8'hA0, 32'h0000_000B);
        bus(1'b1, 8'hB0, 32'h0000_0008);
        bus(1'b1, 8'h10, 32'h0000_0002);
        rd(8'h10, 32'h0000_0002);
        run = 1'b1;
        step(4'h0);
        step(4'h6);
        step(4'h0);
        repeat (8) step(4'($urandom));
        step(4'h0);
        rd(8'h88, cnt);
        rd(8'h04, {28'h000_0000, lat});
        chk(irq, lat[1]);
        bus(1'b1, 8'h0C, 32'h0000_000F);
        // the clear lands at the completing edge; look one edge later
        @(posedge clock);
        chk(irq, 1'b0);
        bus(1'b1, 8'h04, 32'h0000_000F);
        rd(8'h04, 32'h0000_0000);
        // a burst shorter than three ticks must not reach the counter
        icc_field_source_i.hold(4'h1, 150);
        icc_field_source_i.hold(4'h0, 600);
        // a long pulse while the clock enable is low must leave no trace
        @(posedge clock);
        clk_en <= 1'b0;
        icc_field_source_i.hold(4'h1, 600);
        icc_field_source_i.hold(4'h0, 10);
        clk_en <= 1'b1;
        rd(8'h88, cnt);
        bus(1'b1, 8'h80, 32'h0000_0001);
        run = 1'b0;
        step(4'h1);
        step(4'h0);
        rd(8'h88, cnt);
        bus(1'b1, 8'h08, 32'h0000_0001);
        cnt = 0;
        rd(8'h88, 32'h0000_0000);
        bus(1'b1, 8'h80, 32'h0000_0031);
        run = 1'b1;
        step(4'h1);
        step(4'h0);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        rd(8'h88, cnt);
        power_on_rst <= 1'b1;
        repeat (2) @(posedge clock);
        power_on_rst <= 1'b0;
        rd(8'h88, 32'h0000_0000);
        bus(1'b1, 8'h90, 32'h0000_0004);
        repeat (25)
        begin
            icc_field_source_i.hold(4'h2, 500);
            icc_field_source_i.hold(4'h0, 500);
        end
        // ten periods per gate; gate phase allows one edge either way
        bus(1'b0, 8'h9C, 32'h0000_0000);
        chk(q >= 9 && q <= 11, 1'b1);
        give_verdict;
    end
endmodule
